// [rtl/tqd_consts.vh]
// Register map, field positions and reset values of the quadrature decoder
`ifndef TQD_CONSTS_VH
`define TQD_CONSTS_VH
// ----------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------
`define TQD_IDX_X_DIRECTION 16'h2560
`define TQD_IDX_X_COUNT 16'h2561
`define TQD_IDX_Y_DIRECTION 16'h2562
`define TQD_IDX_Y_COUNT 16'h2563
`define TQD_IDX_Z_DIRECTION 16'h2564
`define TQD_IDX_Z_COUNT 16'h2565
`define TQD_IDX_CONTROL 16'h2566
// ----------------------------------------
// Control fields and reset values
// ----------------------------------------
`define TQD_CTL_MODE_BIT 0
`define TQD_CTL_INIT_BIT 1
`define TQD_CTL_ON_BIT 2
`define TQD_CTL_RESET 3'h0
`define TQD_COUNT_RESET 8'h00
`define TQD_DIR_RESET 1'b0
// ----------------------------------------
// Bus answers
// ----------------------------------------
`define TQD_RESP_OKAY 2'h0
`define TQD_RESP_SLVERR 2'h2
`endif

// [rtl/tqd_sync2.v]
// Two-flop synchroniser for the phase pins
`timescale 1ns/1ps
module tqd_sync2 #(
   parameter WIDTH = 6
) (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Data
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta_ff;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta_ff <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end
      else
      begin
         meta_ff <= async_in;
         sync_out <= meta_ff;
      end
   end
endmodule

// [rtl/tqd_axis.v]
// One axis of the quadrature decoder: direction flag and movement count
`include "tqd_consts.vh"
`timescale 1ns/1ps
module tqd_axis #(
   parameter CW = 8
) (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Control
   input wire decoder_on,
   input wire decoder_reinit,
   input wire mode_inc,
   // Synchronised phases
   input wire phase_a,
   input wire phase_b,
   // State
   output reg dir_flag_ff,
   output reg [CW-1:0] count_ff
);
   reg prev_a_ff;
   reg prev_b_ff;
   reg seen_ff;
   reg nxt_dir;
   reg [CW-1:0] nxt_count;
   wire chg_a;
   wire chg_b;
   wire step;
   wire up;

   assign chg_a = phase_a ^ prev_a_ff;
   assign chg_b = phase_b ^ prev_b_ff;
   // One count per cycle with an edge on exactly one phase
   assign step = decoder_on & (chg_a ^ chg_b);
   // B leading A gives up; A leading B gives down
   assign up = chg_a ? (phase_a == phase_b) : (phase_a != phase_b);

   always @*
   begin
      nxt_dir = dir_flag_ff;
      nxt_count = count_ff;
      if (step)
      begin
         nxt_dir = up;
         // Reversal steps by mode; same direction keeps counting up
         if (seen_ff && (up != dir_flag_ff))
            nxt_count = mode_inc ? count_ff + 1'b1 : count_ff - 1'b1;
         else
            nxt_count = count_ff + 1'b1;
      end
   end

   always @(posedge aclk)
   begin
      if (!aresetn || decoder_reinit)
      begin
         dir_flag_ff <= `TQD_DIR_RESET;
         count_ff <= `TQD_COUNT_RESET;
         seen_ff <= 1'b0;
         // Reload history from the synced pins, else reinit makes a false step
         prev_a_ff <= phase_a;
         prev_b_ff <= phase_b;
      end
      else
      begin
         // Track phases even when off so enabling makes no false step
         prev_a_ff <= phase_a;
         prev_b_ff <= phase_b;
         dir_flag_ff <= nxt_dir;
         count_ff <= nxt_count;
         if (step)
            seen_ff <= 1'b1;
      end
   end
endmodule

// [rtl/tqd_top.v]
// Three-axis quadrature decoder with AXI4-Lite register slave
//
// The AXI4-Lite register port was chosen for this implementation.
`include "tqd_consts.vh"
`timescale 1ns/1ps
// Behaviour
// - Three independent phase pairs, one each for X, Y and Z.
// - One count per cycle in which exactly one phase of an axis changes.
// - Phase A changing before B means down.
// - Phase B changing before A means up.
// - Y and Z decode with the same direction rule as X.
// - Direction flag in bit 0, one is up, upper bits zero.
// - Read-only 8-bit movement count per axis, reset to zero.
// - Decoder counts only while control bit 2 is one.
// - Writing one to control bit 1 reinitialises the decoder.
// - Control bit 0 one: count increments on direction reversal.
module tqd_top (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write address
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Phase pins
   input wire x_phase_a,
   input wire x_phase_b,
   input wire y_phase_a,
   input wire y_phase_b,
   input wire z_phase_a,
   input wire z_phase_b
);
   // ----------------------------------------
   // Internal state
   // ----------------------------------------
   reg mode_ff;
   reg on_ff;
   reg init_ff;
   reg [31:0] awaddr_ff;
   reg [31:0] wdata_ff;
   reg [3:0] wstrb_ff;
   reg aw_held_ff;
   reg w_held_ff;
   wire [5:0] phase_sync;
   wire x_dir_flag;
   wire y_dir_flag;
   wire z_dir_flag;
   wire [7:0] x_move_count;
   wire [7:0] y_move_count;
   wire [7:0] z_move_count;
   wire do_write;
   wire ctl_hit;

   // Word index from a byte address; low two bits ignored
   function [15:0] tqd_index;
      input [31:0] addr;
      begin
         tqd_index = addr[17:2];
      end
   endfunction

   // Direction register word: flag in bit 0, reserved bits read zero
   function [31:0] tqd_dir_word;
      input flag;
      begin
         tqd_dir_word = {31'h0, flag};
      end
   endfunction

   // Count register word: 8-bit count, reserved bits read zero
   function [31:0] tqd_count_word;
      input [7:0] count;
      begin
         tqd_count_word = {24'h0, count};
      end
   endfunction

   // Pins are asynchronous to aclk
   tqd_sync2 #(
      .WIDTH(6)
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in({z_phase_b, z_phase_a, y_phase_b, y_phase_a, x_phase_b, x_phase_a}),
      .sync_out(phase_sync)
   );

   // Identical decoders for the three axes
   tqd_axis #(.CW(8)) u_x (
      .aclk(aclk),
      .aresetn(aresetn),
      .decoder_on(on_ff),
      .decoder_reinit(init_ff),
      .mode_inc(mode_ff),
      .phase_a(phase_sync[0]),
      .phase_b(phase_sync[1]),
      .dir_flag_ff(x_dir_flag),
      .count_ff(x_move_count)
   );

   tqd_axis #(.CW(8)) u_y (
      .aclk(aclk),
      .aresetn(aresetn),
      .decoder_on(on_ff),
      .decoder_reinit(init_ff),
      .mode_inc(mode_ff),
      .phase_a(phase_sync[2]),
      .phase_b(phase_sync[3]),
      .dir_flag_ff(y_dir_flag),
      .count_ff(y_move_count)
   );

   tqd_axis #(.CW(8)) u_z (
      .aclk(aclk),
      .aresetn(aresetn),
      .decoder_on(on_ff),
      .decoder_reinit(init_ff),
      .mode_inc(mode_ff),
      .phase_a(phase_sync[4]),
      .phase_b(phase_sync[5]),
      .dir_flag_ff(z_dir_flag),
      .count_ff(z_move_count)
   );

   // ----------------------------------------
   // Write channel
   // ----------------------------------------
   assign do_write = aw_held_ff & w_held_ff & ~s_axi_bvalid;
   assign ctl_hit = (tqd_index(awaddr_ff) == `TQD_IDX_CONTROL);

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b1;
         aw_held_ff <= 1'b0;
         awaddr_ff <= 32'h00000000;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awaddr_ff <= s_axi_awaddr;
            aw_held_ff <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         else if (do_write)
            aw_held_ff <= 1'b0;
         // Next address only once the answer is taken
         if (s_axi_bvalid && s_axi_bready)
            s_axi_awready <= 1'b1;
      end
   end

   // ----------------------------------------
   // Write data capture
   // ----------------------------------------
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_wready <= 1'b1;
         w_held_ff <= 1'b0;
         wdata_ff <= 32'h00000000;
         wstrb_ff <= 4'h0;
      end
      else
      begin
         if (s_axi_wvalid && s_axi_wready)
         begin
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
            w_held_ff <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         else if (do_write)
            w_held_ff <= 1'b0;
         if (s_axi_bvalid && s_axi_bready)
            s_axi_wready <= 1'b1;
      end
   end

   // ----------------------------------------
   // Write response
   // ----------------------------------------
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TQD_RESP_OKAY;
      end
      else if (do_write)
      begin
         s_axi_bvalid <= 1'b1;
         // Only the control register takes writes
         s_axi_bresp <= ctl_hit ? `TQD_RESP_OKAY : `TQD_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // ----------------------------------------
   // Control register
   // ----------------------------------------
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mode_ff <= 1'b0;
         on_ff <= 1'b0;
         init_ff <= 1'b0;
      end
      else
      begin
         // Reinit is a one-cycle strobe, so bit 1 reads back as zero
         init_ff <= 1'b0;
         if (do_write && ctl_hit && wstrb_ff[0])
         begin
            mode_ff <= wdata_ff[`TQD_CTL_MODE_BIT];
            on_ff <= wdata_ff[`TQD_CTL_ON_BIT];
            init_ff <= wdata_ff[`TQD_CTL_INIT_BIT];
         end
      end
   end

   // ----------------------------------------
   // Read channel
   // ----------------------------------------
   reg [31:0] nxt_rdata;
   reg [1:0] nxt_rresp;

   always @*
   begin
      nxt_rresp = `TQD_RESP_OKAY;
      case (tqd_index(s_axi_araddr))
         `TQD_IDX_X_DIRECTION: nxt_rdata = tqd_dir_word(x_dir_flag);
         `TQD_IDX_X_COUNT: nxt_rdata = tqd_count_word(x_move_count);
         `TQD_IDX_Y_DIRECTION: nxt_rdata = tqd_dir_word(y_dir_flag);
         `TQD_IDX_Y_COUNT: nxt_rdata = tqd_count_word(y_move_count);
         `TQD_IDX_Z_DIRECTION: nxt_rdata = tqd_dir_word(z_dir_flag);
         `TQD_IDX_Z_COUNT: nxt_rdata = tqd_count_word(z_move_count);
         `TQD_IDX_CONTROL: nxt_rdata = {29'h0, on_ff, 1'b0, mode_ff};
         default:
         begin
            nxt_rdata = 32'h00000000;
            nxt_rresp = `TQD_RESP_SLVERR;
         end
      endcase
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `TQD_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         // Sampled once at the address edge, so the word stands while waiting
         s_axi_rdata <= nxt_rdata;
         s_axi_rresp <= nxt_rresp;
      end
   end
endmodule

// [sim/tqd_mouse.sv]
// Pointing device model driving three quadrature pairs
`timescale 1ns/1ps
module tqd_mouse (
   // Clock
   input wire aclk,
   // Phase pins
   output reg [2:0] ph_a,
   output reg [2:0] ph_b
);
   initial
   begin
      ph_a = 3'h0;
      ph_b = 3'h0;
   end
   // One quarter-period step; slow spacing lets the pin sync settle
   task step(input int ax, input bit up);
      begin
         @(posedge aclk);
         if (up ^ (ph_a[ax] != ph_b[ax]))
            ph_b[ax] <= ~ph_b[ax];
         else
            ph_a[ax] <= ~ph_a[ax];
         repeat (4) @(posedge aclk);
      end
   endtask
endmodule

// [sim/tqd_top_sva.sv]
// Bus-side checker for the quadrature decoder
`include "tqd_consts.vh"
`timescale 1ns/1ps
module tqd_top_sva (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Bus
   input wire s_axi_awready,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
   property p_r_ans;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_ans: assert property (p_r_ans) else $error("read answer late");
   property p_r_block;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_r_block: assert property (p_r_block) else $error("second read taken");
   property p_b_block;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_b_block: assert property (p_b_block) else $error("second write taken");
   property p_r_rsvd;
      s_axi_rvalid && s_axi_rresp == `TQD_RESP_OKAY |-> s_axi_rdata[31:8] == 24'h0;
   endproperty
   a_r_rsvd: assert property (p_r_rsvd) else $error("upper read bits set");
   property p_r_err;
      s_axi_rvalid && s_axi_rresp != `TQD_RESP_OKAY |->
         s_axi_rresp == `TQD_RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   a_r_err: assert property (p_r_err) else $error("bad error read");
   property p_r_free;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
   endproperty
   a_r_free: assert property (p_r_free) else $error("read not released");
endmodule
bind tqd_top tqd_top_sva CHK (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// [sim/three_axis_quadrature_decoder_bench.sv]
// Register-level bench for the quadrature decoder
`include "tqd_consts.vh"
`timescale 1ns/1ps
module three_axis_quadrature_decoder_bench;
   reg aclk = 1'b0;
   reg aresetn = 1'b0;
   reg [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
   reg [3:0] wstrb = 4'hf;
   reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   wire awready, wready, bvalid, arready, rvalid;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [2:0] pa, pb;
   int err_count = 0, check_count = 0, cyc = 0, i;
   always #20 aclk = ~aclk;
   tqd_mouse M (.aclk(aclk), .ph_a(pa), .ph_b(pb));
   tqd_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .x_phase_a(pa[0]), .x_phase_b(pb[0]), .y_phase_a(pa[1]),
      .y_phase_b(pb[1]), .z_phase_a(pa[2]), .z_phase_b(pb[2]));
   task tally_and_finish;
      begin
         $display("checks %0d mismatches %0d", check_count, err_count);
         if (err_count == 0 && check_count > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 6000)
      begin
         err_count = err_count + 1;
         tally_and_finish;
      end
   end
   task chk(input string nm, input [31:0] e, input [31:0] g);
      begin
         check_count++;
         if (g !== e)
         begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   // Late ready on purpose, so the answer must stand
   task wr(input [15:0] idx, input [31:0] d, input [1:0] er);
      reg aw_ok, w_ok;
      begin
         awaddr <= {14'h0, idx, 2'h0};
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         aw_ok = 1'b0;
         w_ok = 1'b0;
         while (!(aw_ok && w_ok))
         begin
            @(posedge aclk);
            if (awready === 1'b1) begin aw_ok = 1'b1; awvalid <= 1'b0; end
            if (wready === 1'b1) begin w_ok = 1'b1; wvalid <= 1'b0; end
         end
         while (bvalid !== 1'b1) @(posedge aclk);
         bready <= 1'b1;
         @(posedge aclk);
         chk("bresp", {30'h0, er}, {30'h0, bresp});
         bready <= 1'b0;
      end
   endtask
   task rd(input [15:0] idx, input [31:0] e, input [1:0] er);
      begin
         araddr <= {14'h0, idx, 2'h0};
         arvalid <= 1'b1;
         do @(posedge aclk); while (arready !== 1'b1);
         arvalid <= 1'b0;
         while (rvalid !== 1'b1) @(posedge aclk);
         rready <= 1'b1;
         @(posedge aclk);
         chk("rdata", e, rdata);
         chk("rresp", {30'h0, er}, {30'h0, rresp});
         rready <= 1'b0;
      end
   endtask
   initial
   begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (i = 0; i < 7; i++) rd(`TQD_IDX_X_DIRECTION + i[15:0], 0, 0);
      rd(16'h2567, 0, `TQD_RESP_SLVERR);
      wr(`TQD_IDX_X_COUNT, 32'h55, `TQD_RESP_SLVERR);
      M.step(0, 1);
      rd(`TQD_IDX_X_COUNT, 0, 0);
      wr(`TQD_IDX_CONTROL, 32'h4, 0);
      repeat (3) M.step(0, 1);
      rd(`TQD_IDX_X_DIRECTION, 1, 0);
      rd(`TQD_IDX_X_COUNT, 3, 0);
      M.step(0, 0);
      rd(`TQD_IDX_X_DIRECTION, 0, 0);
      rd(`TQD_IDX_X_COUNT, 2, 0);
      M.step(0, 0);
      rd(`TQD_IDX_X_COUNT, 3, 0);
      M.step(1, 0);
      M.step(1, 0);
      M.step(2, 1);
      rd(`TQD_IDX_Y_DIRECTION, 0, 0);
      rd(`TQD_IDX_Y_COUNT, 2, 0);
      rd(`TQD_IDX_Z_DIRECTION, 1, 0);
      wstrb <= 4'h0;
      wr(`TQD_IDX_CONTROL, 32'h5, 0);
      wstrb <= 4'hf;
      rd(`TQD_IDX_CONTROL, 32'h4, 0);
      wr(`TQD_IDX_CONTROL, 32'h5, 0);
      M.step(0, 1);
      rd(`TQD_IDX_X_COUNT, 4, 0);
      wr(`TQD_IDX_CONTROL, 32'h6, 0);
      rd(`TQD_IDX_CONTROL, 32'h4, 0);
      for (i = 0; i < 6; i++) rd(`TQD_IDX_X_DIRECTION + i[15:0], 0, 0);
      repeat (257) M.step(2, 1);
      rd(`TQD_IDX_Z_DIRECTION, 1, 0);
      rd(`TQD_IDX_Z_COUNT, 1, 0);
      tally_and_finish;
   end
endmodule
